// ===== logic/interprocessor_lock_mailbox.sv
// Hardware locks, message words and event interrupt structures.
// Summary of operation
// - Up to 16 channels, 16 interrupt structures.
// - Six registers per channel, all processors.
// - Acquire read takes lock, flag reports grab_ok_flag.
// - Test and take happen in one access.
// - Locked channel acquire read returns zero flag.
// - Acquire read returns holder identity fields.
// - Any release write frees the lock.
// - Release bits raise release events per structure.
// - Notify bits raise notify events per structure.
// - Two independent 32-bit message words per channel.
// - Lock state read shows holder, no side effect.
// - No check of who releases or acquires.
// - Pending has 16 notify, 16 release bits.
// - Writing one clears a pending bit.
// - Writing one to set register sets pending.
// - Only unmasked sources can raise the line.
// - Masked read equals pending AND mask.
// - One interrupt line per interrupt structure.
// - Locks never block message word access.
`timescale 1ns/1ps
`default_nettype none
module interprocessor_lock_mailbox #(
    parameter int NUM_CH  = 16,
    parameter int NUM_INT = 16
) (
    input  wire logic                                clock,
    input  wire logic                                rstn,
    input  wire interprocessor_link_pkg::bus_req_type bus_req,
    output var  interprocessor_link_pkg::bus_rsp_type bus_rsp,
    output logic [NUM_INT-1:0]                       irq_out
);
    import interprocessor_link_pkg::*;

    // The decoder has four index bits for each kind of structure.
    if (NUM_CH < 1 || NUM_CH > MAX_CH ||
        NUM_INT < 1 || NUM_INT > MAX_INT) begin : g_bad_count
        $error("Structure counts must lie between 1 and 16.");
    end

    // Channel state.
    logic        locked_ff  [NUM_CH];  // Lock held flag per channel.
    owner_type   owner_ff   [NUM_CH];  // Holder captured at acquire.
    logic [31:0] word_lo_ff [NUM_CH];  // Low message word.
    logic [31:0] word_hi_ff [NUM_CH];  // High message word.

    // Interrupt structure state.
    logic [31:0] pend_ff    [NUM_INT]; // Sticky event bits.
    logic [31:0] mask_ff    [NUM_INT]; // Enables toward the line.
    logic [31:0] nxt_pend   [NUM_INT]; // Next pending value.
    logic [31:0] event_vec  [NUM_INT]; // Events raised this cycle.

    logic [31:0] nxt_rdata;            // Read data for the answer.

    // Address decode of the single request taken each cycle. Channels sit
    // in the lower half of the map, interrupt structures in the third
    // quarter; the fourth quarter is unmapped and answers with zero.
    logic [3:0] ch_idx;                // Channel addressed.
    logic [4:0] ch_off;                // Register inside the channel.
    logic [3:0] int_idx;               // Interrupt structure addressed.
    logic [3:0] int_off;               // Register inside the structure.
    logic       ch_hit;                // Request targets a channel.
    logic       int_hit;               // Request targets a structure.
    assign ch_idx  = bus_req.addr[8:5];
    assign ch_off  = bus_req.addr[4:0];
    assign int_idx = bus_req.addr[7:4];
    assign int_off = bus_req.addr[3:0];
    assign ch_hit  = bus_req.valid && !bus_req.addr[9]
                     && (32'(ch_idx) < NUM_CH);
    assign int_hit = bus_req.valid && bus_req.addr[9:8] == INT_REGION
                     && (32'(int_idx) < NUM_INT);

    // Per-register strobes. Writes to the acquire and lock state words
    // have no strobe at all, so they fall through as harmless no-ops.
    logic acq_rd, grab, rel_wr, ntf_wr, lo_wr, hi_wr;
    logic pend_wr, set_wr, mask_wr;
    assign acq_rd  = ch_hit && !bus_req.write && ch_off == CH_ACQUIRE;
    assign rel_wr  = ch_hit && bus_req.write && ch_off == CH_RELEASE;
    assign ntf_wr  = ch_hit && bus_req.write && ch_off == CH_NOTIFY;
    assign lo_wr   = ch_hit && bus_req.write && ch_off == CH_DATA_LO;
    assign hi_wr   = ch_hit && bus_req.write && ch_off == CH_DATA_HI;
    assign pend_wr = int_hit && bus_req.write && int_off == INT_PEND;
    assign set_wr  = int_hit && bus_req.write && int_off == INT_SET;
    assign mask_wr = int_hit && bus_req.write && int_off == INT_MASK;

    // Only one request reaches this port per cycle, so test and take
    // cannot be split by another access; the bus arbiter's order picks
    // the winner among processors racing for a free channel.
    assign grab = acq_rd && !locked_ff[ch_idx];

    // Lock flag and holder identity. The holder is not checked on
    // release: software must keep its own discipline here.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                locked_ff[c] <= 1'b0;
                owner_ff[c]  <= '0;
            end
        end else if (grab) begin
            locked_ff[ch_idx] <= 1'b1;
            owner_ff[ch_idx]  <= '{pc: bus_req.pc,
                                   mid: bus_req.mid};
        end else if (rel_wr) begin
            locked_ff[ch_idx] <= 1'b0;
        end
    end

    // Message words take writes whatever the lock says. Keeping the
    // holder away from a half-written message is software's job; the
    // lock is only advisory toward these words.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                word_lo_ff[c] <= WORD_RESET;
                word_hi_ff[c] <= WORD_RESET;
            end
        end else if (lo_wr) begin
            word_lo_ff[ch_idx] <= bus_req.wdata;
        end else if (hi_wr) begin
            word_hi_ff[ch_idx] <= bus_req.wdata;
        end
    end

    // Events raised by notify and release writes, fanned out by bit.
    // Bit i of the written word selects structure i, so one write can
    // wake several structures at once; upper data bits are ignored
    // when fewer structures are built.
    always_comb begin
        for (int i = 0; i < NUM_INT; i++) begin
            event_vec[i] = '0;
            if (ntf_wr && bus_req.wdata[i]) begin
                event_vec[i][NOTIFY_LSB + 32'(ch_idx)] = 1'b1;
            end
            if (rel_wr && bus_req.wdata[i]) begin
                event_vec[i][RELEASE_LSB + 32'(ch_idx)] = 1'b1;
            end
        end
    end

    // Pending next value. Events and forced sets are ORed in after the
    // clear, so an event arriving with its clear is never lost.
    always_comb begin
        for (int i = 0; i < NUM_INT; i++) begin
            nxt_pend[i] = pend_ff[i];
            if (pend_wr && 32'(int_idx) == i) begin
                nxt_pend[i] = nxt_pend[i] & ~bus_req.wdata;
            end
            if (set_wr && 32'(int_idx) == i) begin
                nxt_pend[i] = nxt_pend[i] | bus_req.wdata;
            end
            nxt_pend[i] = nxt_pend[i] | event_vec[i];
        end
    end

    // Pending and mask registers. Every pending word is rewritten on
    // every edge from its next value, which keeps set, clear and event
    // merging in one place.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_INT; i++) begin
                pend_ff[i] <= WORD_RESET;
                mask_ff[i] <= WORD_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_INT; i++) begin
                pend_ff[i] <= nxt_pend[i];
            end
            if (mask_wr) begin
                mask_ff[int_idx] <= bus_req.wdata;
            end
        end
    end

    // One line per structure, high while any enabled event is pending.
    // It is a gate of flip-flops, so it follows the state without delay.
    always_comb begin
        for (int i = 0; i < NUM_INT; i++) begin
            irq_out[i] = |(pend_ff[i] & mask_ff[i]);
        end
    end

    // Read multiplexer; write-only and unmapped addresses read zero.
    // The acquire read shows the caller's own identity when it wins,
    // because the holder flops only load at the edge that ends it.
    always_comb begin
        nxt_rdata = '0;
        if (ch_hit && !bus_req.write) begin
            unique case (ch_off)
                CH_ACQUIRE: nxt_rdata = lock_word(grab, grab ?
                    owner_type'({bus_req.pc, bus_req.mid}) :
                    owner_ff[ch_idx]);
                CH_STATE:   nxt_rdata = lock_word(locked_ff[ch_idx],
                                                  owner_ff[ch_idx]);
                CH_DATA_LO: nxt_rdata = word_lo_ff[ch_idx];
                CH_DATA_HI: nxt_rdata = word_hi_ff[ch_idx];
                default:    nxt_rdata = '0;
            endcase
        end else if (int_hit && !bus_req.write) begin
            unique case (int_off)
                INT_PEND:   nxt_rdata = pend_ff[int_idx];
                INT_MASK:   nxt_rdata = mask_ff[int_idx];
                INT_MASKED: nxt_rdata = pend_ff[int_idx]
                                        & mask_ff[int_idx];
                default:    nxt_rdata = '0;
            endcase
        end
    end

    // Every request is answered on the next edge, mapped or not. There
    // is no wait state, so a master never has to poll for the answer.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            bus_rsp <= '0;
        end else begin
            bus_rsp.ack   <= bus_req.valid;
            bus_rsp.rdata <= nxt_rdata;
        end
    end

    // Checks on the observable behaviour. All of them sleep while reset
    // is low, so a request cut short by reset raises no false alarm.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    logic [31:0] sel_pend;             // Pending of addressed structure.
    logic [31:0] sel_mask;             // Mask of addressed structure.
    logic        sel_locked;           // Lock of addressed channel.
    assign sel_pend   = pend_ff[int_idx];
    assign sel_mask   = mask_ff[int_idx];
    assign sel_locked = locked_ff[ch_idx];

    sequence s_grab_free;
        acq_rd && !sel_locked;
    endsequence
    sequence s_grab_busy;
        acq_rd && sel_locked;
    endsequence
    sequence s_answered_ok;
        bus_rsp.ack && bus_rsp.rdata[GRAB_OK_BIT];
    endsequence

    sequence s_state_read;
        ch_hit && !bus_req.write && ch_off == CH_STATE;
    endsequence
    sequence s_notify_shown;
        ntf_wr && bus_req.wdata[0] && mask_ff[0][NOTIFY_LSB + 32'(ch_idx)];
    endsequence

    // A free channel is taken and the answer reports the win.
    a_acquire_free_wins: assert property (
        s_grab_free |=> s_answered_ok and locked_ff[$past(ch_idx)])
        else $error("Acquire of a free channel did not succeed.");
    // A held channel stays held and the answer reports the loss.
    a_acquire_busy_fails: assert property (
        s_grab_busy |=> bus_rsp.ack && !bus_rsp.rdata[GRAB_OK_BIT]
        && locked_ff[$past(ch_idx)])
        else $error("Acquire of a held channel reported grab_ok_flag.");
    // The winner's identity comes back in the low bits of the answer.
    a_holder_captured: assert property (
        s_grab_free |=>
        bus_rsp.rdata[11:0] == $past({bus_req.pc, bus_req.mid}))
        else $error("Acquire read lost the holder identity.");
    // A loser is told who holds the channel, and the holder stays.
    a_loser_sees_holder: assert property (
        s_grab_busy |=> bus_rsp.rdata[11:0] == owner_ff[$past(ch_idx)])
        else $error("Failed acquire showed the wrong holder.");
    // Any release write frees the lock, whoever sends it.
    a_release_frees: assert property (
        rel_wr |=> !locked_ff[$past(ch_idx)])
        else $error("Release write left the channel locked.");

    // Event fan-out, watched on structure 0, which the tests all reach.
    a_notify_raises: assert property (
        ntf_wr && bus_req.wdata[0] |=>
        pend_ff[0][NOTIFY_LSB + 32'($past(ch_idx))])
        else $error("Notify write did not raise its event.");
    a_release_event: assert property (
        rel_wr && bus_req.wdata[0] |=>
        pend_ff[0][RELEASE_LSB + 32'($past(ch_idx))])
        else $error("Release write did not raise its event.");
    // A release with bit 0 low must leave structure 0 untouched.
    a_release_quiet: assert property (
        rel_wr && !bus_req.wdata[0] |=> pend_ff[0] == $past(pend_ff[0]))
        else $error("Release raised an event that was not asked for.");

    // Software access to the pending bits.
    a_pending_clear: assert property (
        pend_wr |=> (pend_ff[$past(int_idx)] & $past(bus_req.wdata)) == '0)
        else $error("Write of ones did not clear pending bits.");
    // Zeros in a clearing write must leave their bits alone.
    a_pending_keep: assert property (
        pend_wr |=> (pend_ff[$past(int_idx)] & ~$past(bus_req.wdata))
        == $past(sel_pend & ~bus_req.wdata))
        else $error("Write of zeros changed pending bits.");
    a_pending_set: assert property (
        set_wr |=> (pend_ff[$past(int_idx)] & $past(bus_req.wdata))
        == $past(bus_req.wdata))
        else $error("Write of ones did not set pending bits.");

    // Masking, as seen on the read port and on the line.
    a_mask_stored: assert property (
        mask_wr |=> mask_ff[$past(int_idx)] == $past(bus_req.wdata))
        else $error("Mask write was not stored.");
    a_masked_read: assert property (
        int_hit && !bus_req.write && int_off == INT_MASKED |=>
        bus_rsp.rdata == $past(sel_pend & sel_mask))
        else $error("Masked read is not pending AND mask.");
    a_mask_blocks_line: assert property (
        mask_wr && int_idx == 4'h0 && bus_req.wdata == '0 |=> !irq_out[0])
        else $error("Line raised with every source masked.");
    // An unmasked notify reaches the line one edge after the write.
    a_notify_line: assert property (
        s_notify_shown |=> irq_out[0])
        else $error("Unmasked notify did not raise the line.");

    // Message words ignore the lock.
    a_word_lo_open: assert property (
        lo_wr && sel_locked |=>
        word_lo_ff[$past(ch_idx)] == $past(bus_req.wdata))
        else $error("Message word write blocked by the lock.");
    a_word_hi_open: assert property (
        hi_wr |=> word_hi_ff[$past(ch_idx)] == $past(bus_req.wdata))
        else $error("High message word write was lost.");

    // Lock state reads report without disturbing the lock.
    a_state_no_effect: assert property (
        s_state_read |=> locked_ff[$past(ch_idx)] == $past(sel_locked))
        else $error("Lock state read changed the lock.");
    a_state_reports: assert property (
        s_state_read |=> bus_rsp.rdata[GRAB_OK_BIT] == $past(sel_locked))
        else $error("Lock state read shows the wrong flag.");

    // Every request is answered on the next edge, writes with zero.
    a_ack_follows: assert property (
        bus_req.valid |=> bus_rsp.ack)
        else $error("Request was not answered on the next edge.");
    a_ack_unasked: assert property (
        !bus_req.valid |=> !bus_rsp.ack)
        else $error("Answer given with no request.");
    a_write_reads_zero: assert property (
        bus_req.valid && bus_req.write |=> bus_rsp.rdata == '0)
        else $error("Write answer carried read data.");

endmodule : interprocessor_lock_mailbox
`default_nettype wire

// ===== logic/interprocessor_link_pkg.sv
// Shared constants and carrier types for the lock and mailbox block.
package interprocessor_link_pkg;

    // Bus widths and the largest structure counts the decoder can address.
    localparam int ADDR_W  = 10;
    localparam int DATA_W  = 32;
    localparam int MID_W   = 8;
    localparam int PC_W    = 4;
    localparam int MAX_CH  = 16;
    localparam int MAX_INT = 16;

    // Address map: channels own 32 bytes each, interrupt structures 16.
    localparam logic [1:0] INT_REGION = 2'h2;
    localparam logic [4:0] CH_ACQUIRE = 5'h00;
    localparam logic [4:0] CH_NOTIFY  = 5'h04;
    localparam logic [4:0] CH_RELEASE = 5'h08;
    localparam logic [4:0] CH_DATA_LO = 5'h0C;
    localparam logic [4:0] CH_DATA_HI = 5'h10;
    localparam logic [4:0] CH_STATE   = 5'h14;
    localparam logic [3:0] INT_PEND   = 4'h0;
    localparam logic [3:0] INT_SET    = 4'h4;
    localparam logic [3:0] INT_MASK   = 4'h8;
    localparam logic [3:0] INT_MASKED = 4'hC;

    // Field positions inside lock words and pending registers.
    localparam int GRAB_OK_BIT = 31;
    localparam int RELEASE_LSB = 0;
    localparam int NOTIFY_LSB  = 16;

    // Reset value of message words, pending and mask registers.
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // One access request from the arbitrated system bus.
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [MID_W-1:0]  mid;
        logic [PC_W-1:0]   pc;
    } bus_req_type;

    // Answer to a request, one cycle after it is taken.
    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] rdata;
    } bus_rsp_type;

    // Identity of the processor holding a lock.
    typedef struct packed {
        logic [PC_W-1:0]  pc;
        logic [MID_W-1:0] mid;
    } owner_type;

    // Builds a lock word: flag on top, holder identity in the low bits.
    function automatic logic [31:0] lock_word(logic flag, owner_type who);
        lock_word = {flag, 19'h0_0000, who};
    endfunction : lock_word

endpackage : interprocessor_link_pkg

// ===== verif/bus_master_model.sv
// Processor-side model that issues single register accesses on the bus.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input  wire logic                                 clock,
    output var  interprocessor_link_pkg::bus_req_type bus_req,
    input  wire interprocessor_link_pkg::bus_rsp_type bus_rsp
);
    import interprocessor_link_pkg::*;

    // The bus starts idle so no request is seen during reset.
    initial begin
        bus_req = '0;
    end

    // One access: valid for exactly one cycle, answer taken a cycle later.
    // Released address and data lines show the inverse of the last value, so a design that
    // samples them late sees garbage rather than a lucky stale copy.
    // Callers also release channels they do not hold, as the random event traffic does.
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic [MID_W-1:0] m,
        input logic [PC_W-1:0] p, output logic ack,
        output logic [DATA_W-1:0] rd);
        @(posedge clock);
        #1;
        bus_req = '{valid: 1'b1, write: wr, addr: a, wdata: d, mid: m, pc: p};
        @(posedge clock);
        #1;
        bus_req.valid = 1'b0;
        bus_req.addr  = ~a;
        bus_req.wdata = ~d;
        ack = bus_rsp.ack;
        rd  = bus_rsp.rdata;
    endtask : access
endmodule : bus_master_model
`default_nettype wire

// ===== verif/interprocessor_lock_mailbox_bench.sv
// Self-checking bench for the lock and mailbox block.
`timescale 1ns/1ps
`default_nettype none
module interprocessor_lock_mailbox_bench;
    import interprocessor_link_pkg::*;
    logic        clock;       // 25 MHz system clock.
    logic        rstn;        // Synchronous reset, active low.
    bus_req_type bus_req;     // Request from the processor model.
    bus_rsp_type bus_rsp;     // Answer from the design.
    logic [15:0] irq_out;     // One line per interrupt structure.
    logic        ack;         // Last answer's acknowledge.
    logic [31:0] rd;          // Last answer's read data.
    logic [31:0] pend [16];   // Expected pending registers.
    logic [31:0] mask [16];   // Expected mask registers.
    int          err_total;   // Mismatches seen.
    int          check_count; // Comparisons made.

    interprocessor_lock_mailbox u_interprocessor_lock_mailbox (
        .clock(clock), .rstn(rstn), .bus_req(bus_req), .bus_rsp(bus_rsp),
        .irq_out(irq_out));
    bus_master_model u_bus_master_model (
        .clock(clock), .bus_req(bus_req), .bus_rsp(bus_rsp));

    // Free-running clock, 40 ns period.
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Prints the verdict and ends the run; the only exit point.
    task automatic report_and_stop;
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Compares one 32-bit result with four-state equality.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Every access must be acknowledged, whatever its address.
    task automatic rw(input logic wr, input logic [9:0] a,
        input logic [31:0] d, input logic [7:0] m = 8'h00,
        input logic [3:0] p = 4'h0);
        u_bus_master_model.access(wr, a, d, m, p, ack, rd);
        chk({31'h0, ack}, 32'h1);
        if (wr) chk(rd, 32'h0);
    endtask : rw

    // Reads one register and compares the data.
    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp,
        input logic [7:0] m = 8'h00, input logic [3:0] p = 4'h0);
        rw(1'b0, a, 32'h0, m, p);
        chk(rd, exp);
    endtask : rd_chk

    // Expected lock word: flag on top, context and processor id low.
    function automatic logic [31:0] lockw(logic f, logic [7:0] m,
        logic [3:0] p);
        return {f, 19'h0, p, m};
    endfunction : lockw

    // Channel and interrupt structure register addresses.
    function automatic logic [9:0] cha(logic [3:0] c, logic [4:0] o);
        return {1'b0, c, o};
    endfunction : cha
    function automatic logic [9:0] inta(logic [3:0] i, logic [3:0] o);
        return {2'h2, i, o};
    endfunction : inta

    // Checks one structure's registers and all interrupt lines.
    task automatic chk_int(input logic [3:0] i);
        logic [15:0] e;
        rd_chk(inta(i, INT_PEND), pend[i]);
        rd_chk(inta(i, INT_MASK), mask[i]);
        rd_chk(inta(i, INT_MASKED), pend[i] & mask[i]);
        rd_chk(inta(i, INT_SET), 32'h0);
        for (int k = 0; k < 16; k++) e[k] = |(pend[k] & mask[k]);
        chk({16'h0, irq_out}, {16'h0, e});
    endtask : chk_int

    // Watchdog sized well beyond the expected run length.
    initial begin
        #(40 * 30000);
        err_total++;
        report_and_stop();
    end

    // Main sequence: reset, locks and data, then random event traffic.
    initial begin
        logic [7:0]  m1, m2;
        logic [3:0]  p1, p2, c;
        logic [31:0] v;
        int          op;
        rstn = 1'b0;
        err_total = 0;
        check_count = 0;
        void'($urandom(32'hFC1B));
        for (int k = 0; k < 16; k++) begin
            pend[k] = '0;
            mask[k] = '0;
        end
        repeat (12) @(posedge clock);
        #1;
        rstn = 1'b1;
        for (int k = 0; k < 16; k++) chk_int(k[3:0]);
        rw(1'b1, 10'h300, $urandom);
        rd_chk(10'h300, 32'h0);
        for (int k = 0; k < 16; k++) begin
            c  = k[3:0];
            m1 = 8'($urandom);
            m2 = ~m1;
            p1 = 4'($urandom);
            p2 = p1 + 4'h1;
            rd_chk(cha(c, CH_STATE), 32'h0);
            rd_chk(cha(c, CH_ACQUIRE), lockw(1'b1, m1, p1), m1, p1);
            rd_chk(cha(c, CH_ACQUIRE), lockw(1'b0, m1, p1), m2, p2);
            rw(1'b1, cha(c, CH_ACQUIRE), $urandom, m2, p2);
            rd_chk(cha(c, CH_STATE), lockw(1'b1, m1, p1));
            rd_chk(cha(c, CH_NOTIFY), 32'h0);
            v = $urandom;
            rw(1'b1, cha(c, CH_DATA_LO), v, m2, p2);
            rw(1'b1, cha(c, CH_DATA_HI), ~v, m2, p2);
            rd_chk(cha(c, CH_DATA_LO), v, m2, p2);
            rd_chk(cha(c, CH_DATA_HI), ~v);
            rw(1'b1, cha(c, CH_RELEASE), 32'h0, k[0] ? m2 : m1);
            rw(1'b0, cha(c, CH_STATE), 32'h0);
            chk({31'h0, rd[31]}, 32'h0);
            rd_chk(cha(c, CH_ACQUIRE), lockw(1'b1, m2, p2), m2, p2);
            rw(1'b1, cha(c, CH_RELEASE), 32'h0, m2, p2);
        end
        for (int k = 0; k < 16; k++) chk_int(k[3:0]);
        for (int n = 0; n < 300; n++) begin
            op = $urandom_range(0, 4);
            c  = 4'($urandom);
            v  = $urandom & $urandom;
            rw(1'b1, op < 2 ? cha(c, op ? CH_RELEASE : CH_NOTIFY)
                            : inta(c, op == 2 ? INT_PEND
                                  : op == 3 ? INT_SET : INT_MASK), v);
            for (int k = 0; k < 16; k++) begin
                if (op == 0 && v[k]) pend[k][16 + c] = 1'b1;
                if (op == 1 && v[k]) pend[k][c] = 1'b1;
            end
            if (op == 2) pend[c] = pend[c] & ~v;
            if (op == 3) pend[c] = pend[c] | v;
            if (op == 4) mask[c] = v;
            chk_int(4'($urandom));
        end
        for (int k = 0; k < 16; k++) begin
            rw(1'b1, inta(k[3:0], INT_PEND), 32'hFFFF_FFFF);
            pend[k] = '0;
        end
        chk_int(4'h0);
        // Masked sources stay off the line even when all are pending.
        rw(1'b1, inta(4'h0, INT_MASK), 32'h0);
        mask[0] = '0;
        rw(1'b1, inta(4'h0, INT_SET), 32'hFFFF_FFFF);
        pend[0] = 32'hFFFF_FFFF;
        chk_int(4'h0);
        // Reset in mid-run with a lock held and events pending.
        m1 = 8'h5A;
        rd_chk(cha(4'h5, CH_ACQUIRE), lockw(1'b1, m1, 4'h3), m1, 4'h3);
        rstn = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rstn = 1'b1;
        for (int k = 0; k < 16; k++) begin
            pend[k] = '0;
            mask[k] = '0;
        end
        rd_chk(cha(4'h5, CH_STATE), 32'h0);
        chk_int(4'h0);
        report_and_stop();
    end
endmodule : interprocessor_lock_mailbox_bench
`default_nettype wire
